// ### hdl/pdi_pkg.sv
// package of constants and types for the palette converter front end
package pdi_pkg;

    // =====================================================
    // host i/o port addresses
    localparam logic [15:0] ADDR_PIXEL_MASK  = 16'h03c6;
    localparam logic [15:0] ADDR_READ_PTR    = 16'h03c7;
    localparam logic [15:0] ADDR_LAST_OP     = 16'h03c7;
    localparam logic [15:0] ADDR_WRITE_PTR   = 16'h03c8;
    localparam logic [15:0] ADDR_COLOR_PORT  = 16'h03c9;

    // =====================================================
    // palette geometry and field layout
    localparam int          NUM_ENTRIES      = 256;
    localparam int          INDEX_W          = 8;
    localparam int          ENTRY_W          = 18;
    localparam int          FIELD_W          = 6;
    localparam int          RED_LSB          = 12;
    localparam int          GREEN_LSB        = 6;
    localparam int          BLUE_LSB         = 0;
    localparam int          BYTE_W           = 8;

    // =====================================================
    // read values and reset values
    localparam logic [7:0]  PIXEL_MASK_VALUE = 8'hff;
    localparam logic [7:0]  UNMAPPED_VALUE   = 8'h00;
    localparam logic [1:0]  LAST_OP_READ     = 2'h3;
    localparam logic [1:0]  LAST_OP_WRITE    = 2'h0;
    localparam logic [7:0]  PTR_RESET        = 8'h00;
    localparam logic [17:0] ENTRY_RESET      = 18'h00000;

    // =====================================================
    // timing and buffering
    localparam int          PEL_LATENCY      = 3;
    localparam int          RDBUF_DEPTH      = 2;

    // byte position inside a three-byte palette cycle
    typedef enum logic [1:0] {PH_RED, PH_GREEN, PH_BLUE} pdi_phase_t;
    // direction of the cycle in progress
    typedef enum logic {MODE_WRITE, MODE_READ} pdi_mode_t;

endpackage : pdi_pkg

// ### hdl/pdi_stream_if.sv
// valid/ready byte stream between the register logic and its read buffer
`timescale 1ns/1ns
`default_nettype none
interface pdi_stream_if;
    logic       valid;
    logic       ready;
    logic [7:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : pdi_stream_if
`default_nettype wire

// ### hdl/pdi_rd_buf.sv
// two-entry buffer for host read answers
`timescale 1ns/1ns
`default_nettype none
module pdi_rd_buf (
    input  wire logic     core_clk,
    input  wire logic     srst,
    pdi_stream_if.snk     inPort,
    pdi_stream_if.src     outPort
);
    import pdi_pkg::*;

    logic [7:0] slot_q [RDBUF_DEPTH];
    logic       wrSel_q;
    logic       rdSel_q;
    logic [1:0] count_q;
    logic       push;
    logic       pop;

    // =====================================================
    // flags and handshakes
    assign inPort.ready  = (count_q != 2'(RDBUF_DEPTH));
    assign outPort.valid = (count_q != 2'h0);
    assign outPort.data  = slot_q[rdSel_q];
    assign push          = inPort.valid & inPort.ready;
    assign pop           = outPort.valid & outPort.ready;

    // storage slots, written only on push
    always_ff @(posedge core_clk) begin
        if (srst) begin
            slot_q[0] <= 8'h00;
            slot_q[1] <= 8'h00;
        end else if (push) begin
            slot_q[wrSel_q] <= inPort.data;
        end
    end

    // pointers and fill level
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrSel_q <= 1'b0;
            rdSel_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            wrSel_q <= wrSel_q ^ push;
            rdSel_q <= rdSel_q ^ pop;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule : pdi_rd_buf
`default_nettype wire

// ### hdl/pdi_pel_pipe.sv
// pel index pipeline: sample, look up, blank, present
`timescale 1ns/1ns
`default_nettype none
module pdi_pel_pipe (
    input  wire logic                core_clk,
    input  wire logic                srst,
    input  wire logic [7:0]          pelIndexInputs,
    input  wire logic                blankActive,
    output logic [7:0]               lookupIdx,
    input  wire logic [17:0]         lookupEntry,
    output logic [5:0]               redLevel,
    output logic [5:0]               greenLevel,
    output logic [5:0]               blueLevel
);
    import pdi_pkg::*;

    logic [7:0]  idx_q;
    logic        blank1_q;
    logic [17:0] color_q;
    logic        blank2_q;
    logic [17:0] mid_q;
    logic [17:0] out_q;
    logic [17:0] out_d;

    assign lookupIdx = idx_q;
    // blanking wins over any palette value
    assign out_d     = blank2_q ? ENTRY_RESET : color_q;

    // edge 0 samples, edge 3 presents the colour
    always_ff @(posedge core_clk) begin
        if (srst) begin
            idx_q    <= PTR_RESET;
            blank1_q <= 1'b1;
            color_q  <= ENTRY_RESET;
            blank2_q <= 1'b1;
            mid_q    <= ENTRY_RESET;
            out_q    <= ENTRY_RESET;
        end else begin
            idx_q    <= pelIndexInputs;
            blank1_q <= blankActive;
            color_q  <= lookupEntry;
            blank2_q <= blank1_q;
            mid_q    <= out_d; // blank applied on edge 2
            out_q    <= mid_q;
        end
    end

    // one field for each colour converter
    assign redLevel   = out_q[RED_LSB +: FIELD_W];
    assign greenLevel = out_q[GREEN_LSB +: FIELD_W];
    assign blueLevel  = out_q[BLUE_LSB +: FIELD_W];
endmodule : pdi_pel_pipe
`default_nettype wire

// ### hdl/pdi_palette_dac.sv
// palette converter front end: host register port, palette store, pel path
// Summary of operation
// - sample index and blank, output three cycles later
// - 256 entries of 18 bits, index selects
// - entry splits into red, green, blue fields
// - blanking forces all colour outputs to zero
// - write-address port loads pointer, starts write
// - three bytes red green blue, low six bits
// - read-address load starts three-byte read cycle
// - pointer auto-advances over streamed entries
// - address write abandons partial cycle
// - state register shows last operation
// - pointer and state reads disturb nothing
`timescale 1ns/1ns
`default_nettype none
module pdi_palette_dac (
    input  wire logic        core_clk,
    input  wire logic        srst,
    // host i/o strobes, same clock as the block
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWrEn,
    input  wire logic [7:0]  ioWrData,
    input  wire logic        ioRdEn,
    output logic             ioRdReady,
    output logic             ioRdValid,
    output logic [7:0]       ioRdData,
    input  wire logic        ioRdTaken,
    // pel side
    input  wire logic [7:0]  pelIndexInputs,
    input  wire logic        blankActive,
    output logic [5:0]       redLevel,
    output logic [5:0]       greenLevel,
    output logic [5:0]       blueLevel,
    output logic [1:0]       lastOpState
);
    import pdi_pkg::*;

    // =====================================================
    // declarations
    logic [17:0]  pal_q [NUM_ENTRIES];
    logic [7:0]   ptr_q;
    logic [7:0]   ptr_d;
    pdi_phase_t   phase_q;
    pdi_phase_t   phase_d;
    pdi_mode_t    mode_q;
    pdi_mode_t    mode_d;
    logic [5:0]   red_q;
    logic [5:0]   green_q;
    logic [5:0]   holdRed_d;
    logic [5:0]   holdGreen_d;

    logic         hitMask;
    logic         hitLastOp;
    logic         hitWritePtr;
    logic         hitReadPtr;
    logic         hitColor;
    logic         rdTake;
    logic         loadWrite;
    logic         loadRead;
    logic         anyLoad;
    logic         colorWr;
    logic         colorRd;
    logic         colorStep;
    logic         lastByte;
    logic         commit;
    logic [17:0]  commitEntry;
    logic [17:0]  curEntry;
    logic [5:0]   curField;
    logic [7:0]   rdByte;
    logic [7:0]   lookupIdx;
    logic [17:0]  lookupEntry;

    pdi_stream_if rdIn ();
    pdi_stream_if rdOut ();

    // =====================================================
    // address decode
    assign hitMask     = (ioAddr == ADDR_PIXEL_MASK);
    assign hitLastOp   = (ioAddr == ADDR_LAST_OP);
    assign hitReadPtr  = (ioAddr == ADDR_READ_PTR);
    assign hitWritePtr = (ioAddr == ADDR_WRITE_PTR);
    assign hitColor    = (ioAddr == ADDR_COLOR_PORT);

    // reads are only taken while the answer buffer has room
    assign rdTake      = ioRdEn & rdIn.ready;

    // pointer loads; the read-address port is write-only
    assign loadWrite   = ioWrEn & hitWritePtr;
    assign loadRead    = ioWrEn & hitReadPtr;
    assign anyLoad     = loadWrite | loadRead;

    // data port traffic; the wrong direction for the cycle is
    // ignored so the palette can never be corrupted by it
    assign colorWr     = ioWrEn & hitColor & (mode_q == MODE_WRITE) & ~anyLoad;
    assign colorRd     = rdTake & hitColor & (mode_q == MODE_READ) & ~anyLoad;
    assign colorStep   = colorWr | colorRd;
    assign lastByte    = (phase_q == PH_BLUE);
    assign commit      = colorWr & lastByte;

    // =====================================================
    // byte phase, pointer and mode next state
    always_comb begin
        phase_d = phase_q;
        ptr_d   = ptr_q;
        mode_d  = mode_q;
        if (anyLoad) begin
            // a new address drops any half-done cycle
            phase_d = PH_RED;
            ptr_d   = ioWrData;
            mode_d  = loadRead ? MODE_READ : MODE_WRITE;
        end else if (colorStep) begin
            case (phase_q)
                PH_RED: begin
                    phase_d = PH_GREEN;
                end
                PH_GREEN: begin
                    phase_d = PH_BLUE;
                end
                PH_BLUE: begin
                    phase_d = PH_RED;
                    ptr_d   = ptr_q + 8'h01;
                end
                default: begin
                    phase_d = PH_RED;
                end
            endcase
        end
    end

    // control registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            phase_q <= PH_RED;
            ptr_q   <= PTR_RESET;
            mode_q  <= MODE_WRITE;
        end else begin
            phase_q <= phase_d;
            ptr_q   <= ptr_d;
            mode_q  <= mode_d;
        end
    end

    // =====================================================
    // write cycle: hold red and green until blue arrives
    assign holdRed_d   = (colorWr && phase_q == PH_RED) ? ioWrData[5:0] : red_q;
    assign holdGreen_d = (colorWr && phase_q == PH_GREEN) ? ioWrData[5:0] : green_q;
    assign commitEntry = {red_q, green_q, ioWrData[5:0]};

    // held colour bytes; a partial cycle simply never commits
    always_ff @(posedge core_clk) begin
        if (srst) begin
            red_q   <= 6'h00;
            green_q <= 6'h00;
        end else begin
            red_q   <= holdRed_d;
            green_q <= holdGreen_d;
        end
    end

    // =====================================================
    // palette store, one flop group per entry
    generate
        for (genvar e = 0; e < NUM_ENTRIES; e++) begin : gEntry
            logic hitEntry;
            assign hitEntry = commit & (ptr_q == 8'(e));
            always_ff @(posedge core_clk) begin
                if (srst) begin
                    pal_q[e] <= ENTRY_RESET;
                end else if (hitEntry) begin
                    pal_q[e] <= commitEntry;
                end
            end
        end
    endgenerate

    // =====================================================
    // read cycle: pick the field for the current byte
    assign curEntry = pal_q[ptr_q];
    assign curField = (phase_q == PH_RED)   ? curEntry[RED_LSB +: FIELD_W] :
                      (phase_q == PH_GREEN) ? curEntry[GREEN_LSB +: FIELD_W] :
                                              curEntry[BLUE_LSB +: FIELD_W];

    // read answer mux; pointer and state reads have no side effect
    assign rdByte = hitColor    ? ((mode_q == MODE_READ) ? {2'b00, curField} : UNMAPPED_VALUE) :
                    hitWritePtr ? ptr_q :
                    hitLastOp   ? {6'h00, lastOpState} :
                    hitMask     ? PIXEL_MASK_VALUE :
                                  UNMAPPED_VALUE;

    // state register follows the direction of the last cycle
    assign lastOpState = (mode_q == MODE_READ) ? LAST_OP_READ : LAST_OP_WRITE;

    // =====================================================
    // answer buffer: a host that stalls its taken strobe
    // fills it, then further reads are refused by ioRdReady
    assign rdIn.valid  = rdTake;
    assign rdIn.data   = rdByte;
    assign ioRdReady   = rdIn.ready;
    assign ioRdValid   = rdOut.valid;
    assign ioRdData    = rdOut.data;
    assign rdOut.ready = ioRdTaken;

    pdi_rd_buf uRdBuf (
        .core_clk (core_clk),
        .srst     (srst),
        .inPort   (rdIn),
        .outPort  (rdOut)
    );

    // =====================================================
    // pel path; lookup reads the same flops the host writes,
    // so a write during active video may show for a frame
    assign lookupEntry = pal_q[lookupIdx];

    pdi_pel_pipe uPelPipe (
        .core_clk       (core_clk),
        .srst           (srst),
        .pelIndexInputs (pelIndexInputs),
        .blankActive    (blankActive),
        .lookupIdx      (lookupIdx),
        .lookupEntry    (lookupEntry),
        .redLevel       (redLevel),
        .greenLevel     (greenLevel),
        .blueLevel      (blueLevel)
    );
endmodule : pdi_palette_dac
`default_nettype wire

// ### test/pdi_palette_dac_chk.sv
// port assertions for the palette converter front end
`timescale 1ns/1ns
`default_nettype none
module pdi_palette_dac_chk (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic [15:0] ioAddr,
    input wire logic        ioWrEn,
    input wire logic [7:0]  ioWrData,
    input wire logic        ioRdEn,
    input wire logic        ioRdReady,
    input wire logic        ioRdValid,
    input wire logic [7:0]  ioRdData,
    input wire logic        ioRdTaken,
    input wire logic [7:0]  pelIndexInputs,
    input wire logic        blankActive,
    input wire logic [5:0]  redLevel,
    input wire logic [5:0]  greenLevel,
    input wire logic [5:0]  blueLevel,
    input wire logic [1:0]  lastOpState
);
    import pdi_pkg::*;
    // ==========
    // helpers: read taken, address port load
    wire rdTake   = ioRdEn && ioRdReady;
    wire addrLoad = ioWrEn && (ioAddr == ADDR_READ_PTR || ioAddr == ADDR_WRITE_PTR);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // ==========
    // assertions
    a_blank_zero: assert property (blankActive |-> ##4 {redLevel, greenLevel, blueLevel} == 18'h00000)
        else $error("colour not zero after blank");
    a_rd_stands: assert property (ioRdValid && !ioRdTaken |=> ioRdValid && $stable(ioRdData))
        else $error("read answer changed before taken");
    a_ready_empty: assert property (!ioRdValid |-> ioRdReady)
        else $error("not ready with empty buffer");
    a_rd_answer: assert property (rdTake && !ioRdValid |=> ioRdValid)
        else $error("read answer late");
    a_rd_cause: assert property ($rose(ioRdValid) |-> $past(rdTake))
        else $error("answer without read");
    a_full_refuse: assert property (ioRdValid && !ioRdTaken && !ioRdReady |=> !ioRdReady)
        else $error("full buffer drained without take");
    a_state_read: assert property (ioWrEn && ioAddr == ADDR_READ_PTR |=> lastOpState == LAST_OP_READ)
        else $error("state not read after read load");
    a_state_write: assert property (ioWrEn && ioAddr == ADDR_WRITE_PTR |=> lastOpState == LAST_OP_WRITE)
        else $error("state not write after write load");
    a_state_hold: assert property (!addrLoad |=> $stable(lastOpState))
        else $error("state moved without address load");
    // main scenarios seen
    c_blank: cover property (blankActive);
    c_full: cover property (!ioRdReady);
    c_load: cover property (addrLoad ##1 rdTake);
endmodule : pdi_palette_dac_chk
bind pdi_palette_dac pdi_palette_dac_chk u_chk (.core_clk, .srst, .ioAddr, .ioWrEn, .ioWrData, .ioRdEn,
    .ioRdReady, .ioRdValid, .ioRdData, .ioRdTaken, .pelIndexInputs, .blankActive, .redLevel, .greenLevel,
    .blueLevel, .lastOpState);
`default_nettype wire

// ### test/pdi_host_model.sv
// host processor model: byte-wide i/o writes and reads
`timescale 1ns/1ns
`default_nettype none
module pdi_host_model (
    input  wire logic        core_clk,
    output logic [15:0]      ioAddr,
    output logic             ioWrEn,
    output logic [7:0]       ioWrData,
    output logic             ioRdEn,
    input  wire logic        ioRdReady,
    input  wire logic        ioRdValid,
    input  wire logic [7:0]  ioRdData,
    output logic             ioRdTaken
);
    int stall = 0;  // cycles held off before taking an answer
    // ==========
    // idle bus
    initial begin
        ioAddr    = 16'h0000;
        ioWrEn    = 1'b0;
        ioWrData  = 8'h00;
        ioRdEn    = 1'b0;
        ioRdTaken = 1'b0;
    end
    // one byte write over one edge; released lines flip so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #2;
        ioAddr   = a;
        ioWrEn   = 1'b1;
        ioWrData = d;
        @(posedge core_clk);
        #2;
        ioWrEn   = 1'b0;
        ioAddr   = ~a;
        ioWrData = ~d;
    endtask : wr
    // read request held until an edge with ready
    task automatic rdq(input logic [15:0] a);
        @(posedge core_clk);
        #2;
        ioAddr = a;
        ioRdEn = 1'b1;
        while (ioRdReady !== 1'b1) begin
            @(posedge core_clk);
            #2;
        end
        @(posedge core_clk);
        #2;
        ioRdEn = 1'b0;
        ioAddr = ~a;
    endtask : rdq
    // take one answer, optionally after a stall
    task automatic take(output logic [7:0] d);
        repeat (stall) begin
            @(posedge core_clk);
            #2;
        end
        while (ioRdValid !== 1'b1) begin
            @(posedge core_clk);
            #2;
        end
        ioRdTaken = 1'b1;
        d         = ioRdData;
        @(posedge core_clk);
        #2;
        ioRdTaken = 1'b0;
    endtask : take
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        rdq(a);
        take(d);
    endtask : rd
endmodule : pdi_host_model
`default_nettype wire

// ### test/pdi_palette_dac_tb.sv
// self-checking bench for the palette converter front end
`timescale 1ns/1ns
`default_nettype none
module pdi_palette_dac_tb;
    import pdi_pkg::*;
    logic        core_clk, srst, ioWrEn, ioRdEn, ioRdTaken, ioRdReady, ioRdValid, blankActive;
    logic [15:0] ioAddr;
    logic [7:0]  ioWrData, ioRdData, pelIndexInputs, got;
    logic [5:0]  redLevel, greenLevel, blueLevel;
    logic [1:0]  lastOpState;
    int          n_errors = 0;
    int          tests_run = 0;
    pdi_palette_dac u_dut (.core_clk, .srst, .ioAddr, .ioWrEn, .ioWrData, .ioRdEn, .ioRdReady, .ioRdValid,
        .ioRdData, .ioRdTaken, .pelIndexInputs, .blankActive, .redLevel, .greenLevel, .blueLevel, .lastOpState);
    pdi_host_model u_host (.core_clk, .ioAddr, .ioWrEn, .ioWrData, .ioRdEn, .ioRdReady, .ioRdValid, .ioRdData,
        .ioRdTaken);
    // ==========
    // clock, 20 ns
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // field k of the pattern stored at entry n
    function automatic logic [5:0] fld(input logic [7:0] n, input int k);
        return 6'(n + 8'(k * 7));
    endfunction : fld
    function automatic logic [17:0] ent(input logic [7:0] n);
        return {fld(n, 0), fld(n, 1), fld(n, 2)};
    endfunction : ent
    task automatic chkByte(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %0t byte got %h exp %h", $time, g, e);
        end
    endtask : chkByte
    task automatic chkCol(input logic [17:0] e);
        tests_run++;
        if ({redLevel, greenLevel, blueLevel} !== e) begin
            n_errors++;
            $display("[FAIL] %0t colour got %h exp %h", $time, {redLevel, greenLevel, blueLevel}, e);
        end
    endtask : chkCol
    task automatic wrap_up;
        if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // ==========
    // streamed entry writes and read-backs; upper byte bits set to prove they drop
    task automatic wrEntries(input logic [7:0] s, input int cnt);
        u_host.wr(ADDR_WRITE_PTR, s);
        for (int i = 0; i < cnt; i++) begin
            for (int k = 0; k < 3; k++) u_host.wr(ADDR_COLOR_PORT, {2'b11, fld(8'(s + i), k)});
        end
    endtask : wrEntries
    task automatic rdEntries(input logic [7:0] s, input int cnt);
        u_host.wr(ADDR_READ_PTR, s);
        for (int i = 0; i < cnt; i++) begin
            for (int k = 0; k < 3; k++) begin
                u_host.rd(ADDR_COLOR_PORT, got);
                chkByte(got, {2'b00, fld(8'(s + i), k)});
            end
        end
    endtask : rdEntries
    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        wrap_up();
    end
    // ==========
    // main sequence; data port is never used against the cycle direction
    initial begin
        srst           = 1'b1;
        pelIndexInputs = 8'h00;
        blankActive    = 1'b0;
        repeat (16) @(posedge core_clk);
        #2;
        srst = 1'b0;
        chkByte({6'h00, lastOpState}, 8'h00);
        wrEntries(8'hfe, 4);
        u_host.rd(ADDR_WRITE_PTR, got);
        chkByte(got, 8'h02);
        u_host.rd(ADDR_LAST_OP, got);
        chkByte(got, 8'h00);
        rdEntries(8'hfe, 4);
        chkByte({6'h00, lastOpState}, 8'h03);
        // partial write abandoned by a fresh load
        u_host.wr(ADDR_WRITE_PTR, 8'h40);
        u_host.wr(ADDR_COLOR_PORT, 8'h15);
        u_host.wr(ADDR_COLOR_PORT, 8'h16);
        u_host.rd(ADDR_WRITE_PTR, got);
        chkByte(got, 8'h40);
        wrEntries(8'h40, 1);
        // status reads in mid read cycle
        u_host.wr(ADDR_READ_PTR, 8'h40);
        u_host.rd(ADDR_COLOR_PORT, got);
        chkByte(got, {2'b00, fld(8'h40, 0)});
        u_host.rd(ADDR_WRITE_PTR, got);
        chkByte(got, 8'h40);
        u_host.rd(ADDR_LAST_OP, got);
        chkByte(got, 8'h03);
        u_host.rd(ADDR_COLOR_PORT, got);
        chkByte(got, {2'b00, fld(8'h40, 1)});
        u_host.rd(ADDR_COLOR_PORT, got);
        chkByte(got, {2'b00, fld(8'h40, 2)});
        u_host.wr(ADDR_READ_PTR, 8'hfe);
        u_host.rd(ADDR_COLOR_PORT, got);
        chkByte(got, {2'b00, fld(8'hfe, 0)});
        rdEntries(8'hff, 1);
        // fill the answer buffer while the host stalls
        u_host.rdq(16'h0100);
        u_host.rdq(ADDR_PIXEL_MASK);
        chkByte({7'h00, ioRdReady}, 8'h00);
        u_host.stall = 3;
        u_host.take(got);
        chkByte(got, UNMAPPED_VALUE);
        u_host.take(got);
        chkByte(got, PIXEL_MASK_VALUE);
        u_host.stall = 0;
        // pel path latency, field split and blanking
        pelIndexInputs = 8'hfe;
        repeat (6) @(posedge core_clk);
        #2;
        chkCol(ent(8'hfe));
        pelIndexInputs = 8'h40;
        repeat (3) @(posedge core_clk);
        #2;
        chkCol(ent(8'hfe));
        @(posedge core_clk);
        #2;
        chkCol(ent(8'h40));
        blankActive = 1'b1;
        repeat (4) @(posedge core_clk);
        #2;
        chkCol(18'h00000);
        blankActive = 1'b0;
        wrap_up();
    end
endmodule : pdi_palette_dac_tb
`default_nettype wire
